// File: core/wdt_pkg.sv
package wdt_pkg;

	// ----------------------------------------------------------------
	// Counter widths
	// ----------------------------------------------------------------
	localparam int C0_WIDTH = 16;
	localparam int C1_WIDTH = 16;
	localparam int C2_WIDTH = 32;

	// ----------------------------------------------------------------
	// Clock and timing
	// ----------------------------------------------------------------
	localparam int CLK_FREQ_HZ = 25_000_000;
	localparam int CLK_PERIOD_NS = 40;
	// Low-frequency step that drives counters 0 and 2.
	localparam int LF_FREQ_HZ = 32_768;
	localparam int LF_DIV_CYCLES = CLK_FREQ_HZ / LF_FREQ_HZ;
	localparam int LF_DIV_W = 10;
	localparam logic [LF_DIV_W-1:0] LF_DIV_LAST =
		LF_DIV_W'(LF_DIV_CYCLES - 1);
	// Tick period of counter 1, counted in reference clock cycles.
	localparam int TICK_PERIOD_NS = 1_250_000;
	localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;

	// ----------------------------------------------------------------
	// Unserviced tally and system reset pulse
	// ----------------------------------------------------------------
	localparam int MISS_W = 2;
	localparam logic [MISS_W-1:0] MISS_LAST = 2'h2;
	localparam logic [MISS_W-1:0] MISS_ZERO = 2'h0;
	localparam int RESET_PULSE_CYCLES = 16;
	localparam int RST_CNT_W = 4;
	localparam logic [RST_CNT_W-1:0] RST_CNT_LAST =
		RST_CNT_W'(RESET_PULSE_CYCLES - 1);
	localparam logic [C2_WIDTH-1:0] C2_MATCH = 32'hFFFF_FFFF;

	typedef enum logic [0:0] {
		ST_RUN,
		ST_RESET
	} wdt_state_t;

endpackage

// File: core/wdt_counter.sv
module wdt_counter #(
	parameter int WIDTH = 16
) (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic step,
	input wire logic clear,
	input wire logic [WIDTH-1:0] match,
	output logic [WIDTH-1:0] count,
	output logic hit
);

	logic [WIDTH-1:0] count_reg;
	logic [WIDTH-1:0] count_next;
	logic hit_reg;
	logic hit_next;

	// Counts steps up to the terminal value, wraps and flags a hit.
	always_comb begin
		count_next = count_reg;
		hit_next = 1'b0;
		if (clear) begin
			count_next = '0;
		end else if (step) begin
			if (count_reg == match) begin
				count_next = '0;
				hit_next = 1'b1;
			end else begin
				count_next = count_reg + 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			count_reg <= '0;
			hit_reg <= 1'b0;
		end else begin
			count_reg <= count_next;
			hit_reg <= hit_next;
		end
	end

	assign count = count_reg;
	assign hit = hit_reg;

endmodule

// File: core/watchdog_timer.sv
// Operation
// - Three independent counters: two of 16 bits, one of 32 bits.
// - Counter 1 raises a tick interrupt every 1.25 ms, except while the system reset is asserted.
// - Counter 0 raises an interrupt when it reaches its terminal value.
// - Programmable counter 0 terminal; all ones gives about two seconds.
// - Three unhandled counter 0 interrupts in a row issue a system reset.
// - The watchdog reset restarts the whole processor from its start.
module watchdog_timer #(
	parameter int TICK_CYCLES = wdt_pkg::TICK_CYCLES
) (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic c0_clear,
	input wire logic [wdt_pkg::C0_WIDTH-1:0] c0_match,
	input wire logic c0_irq_ack,
	input wire logic tick_irq_ack,
	output logic tick_irq,
	output logic c0_irq,
	output logic sys_reset,
	output logic [wdt_pkg::C0_WIDTH-1:0] c0_count,
	output logic [wdt_pkg::C1_WIDTH-1:0] c1_count,
	output logic [wdt_pkg::C2_WIDTH-1:0] c2_count
);

	localparam logic [wdt_pkg::C1_WIDTH-1:0] C1_MATCH =
		wdt_pkg::C1_WIDTH'(TICK_CYCLES - 1);

	// ----------------------------------------------------------------
	// Low-frequency step divider
	// ----------------------------------------------------------------
	logic [wdt_pkg::LF_DIV_W-1:0] lf_cnt_reg;
	logic [wdt_pkg::LF_DIV_W-1:0] lf_cnt_next;
	logic lf_step_reg;
	logic lf_step_next;

	always_comb begin
		lf_step_next = 1'b0;
		lf_cnt_next = lf_cnt_reg + 1'b1;
		if (lf_cnt_reg == wdt_pkg::LF_DIV_LAST) begin
			lf_cnt_next = '0;
			lf_step_next = 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			lf_cnt_reg <= '0;
			lf_step_reg <= 1'b0;
		end else begin
			lf_cnt_reg <= lf_cnt_next;
			lf_step_reg <= lf_step_next;
		end
	end

	// ----------------------------------------------------------------
	// Counters
	// ----------------------------------------------------------------
	wdt_pkg::wdt_state_t state_reg;
	wdt_pkg::wdt_state_t state_next;
	logic in_reset;
	logic c0_hit;
	logic c1_hit;
	logic c2_hit;

	// All counters are cleared while the system reset is asserted, and read zero from its second cycle on.
	assign in_reset = (state_reg == wdt_pkg::ST_RESET);

	wdt_counter #(.WIDTH(wdt_pkg::C0_WIDTH)) u_cnt0 (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.step(lf_step_reg),
		.clear(c0_clear | in_reset),
		.match(c0_match),
		.count(c0_count),
		.hit(c0_hit)
	);

	wdt_counter #(.WIDTH(wdt_pkg::C1_WIDTH)) u_cnt1 (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.step(1'b1),
		.clear(in_reset),
		.match(C1_MATCH),
		.count(c1_count),
		.hit(c1_hit)
	);

	wdt_counter #(.WIDTH(wdt_pkg::C2_WIDTH)) u_cnt2 (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.step(lf_step_reg),
		.clear(in_reset),
		.match(wdt_pkg::C2_MATCH),
		.count(c2_count),
		.hit(c2_hit)
	);

	// ----------------------------------------------------------------
	// Interrupt flags and unhandled tally
	// ----------------------------------------------------------------
	logic tick_irq_reg;
	logic tick_irq_next;
	logic c0_irq_reg;
	logic c0_irq_next;
	logic [wdt_pkg::MISS_W-1:0] miss_reg;
	logic [wdt_pkg::MISS_W-1:0] miss_next;
	logic fire;

	// A new terminal event wins over a clear or acknowledge in the
	// same cycle, so no event is lost.
	always_comb begin
		logic [wdt_pkg::MISS_W-1:0] base;
		base = miss_reg;
		fire = 1'b0;
		tick_irq_next = (tick_irq_reg & ~tick_irq_ack) | c1_hit;
		c0_irq_next = (c0_irq_reg & ~c0_irq_ack) | c0_hit;
		if (c0_clear || c0_irq_ack) begin
			base = wdt_pkg::MISS_ZERO;
		end
		miss_next = base;
		if (c0_hit) begin
			if (base == wdt_pkg::MISS_LAST) begin
				fire = 1'b1;
				miss_next = wdt_pkg::MISS_ZERO;
			end else begin
				miss_next = base + 1'b1;
			end
		end
		if (in_reset) begin
			fire = 1'b0;
			tick_irq_next = 1'b0;
			c0_irq_next = 1'b0;
			miss_next = wdt_pkg::MISS_ZERO;
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			tick_irq_reg <= 1'b0;
			c0_irq_reg <= 1'b0;
			miss_reg <= '0;
		end else begin
			tick_irq_reg <= tick_irq_next;
			c0_irq_reg <= c0_irq_next;
			miss_reg <= miss_next;
		end
	end

	assign tick_irq = tick_irq_reg;
	assign c0_irq = c0_irq_reg;

	// ----------------------------------------------------------------
	// System reset sequencer
	// ----------------------------------------------------------------
	logic [wdt_pkg::RST_CNT_W-1:0] rst_cnt_reg;
	logic [wdt_pkg::RST_CNT_W-1:0] rst_cnt_next;
	logic sys_reset_reg;
	logic sys_reset_next;

	always_comb begin
		state_next = state_reg;
		rst_cnt_next = rst_cnt_reg;
		case (state_reg)
			wdt_pkg::ST_RUN: begin
				if (fire) begin
					state_next = wdt_pkg::ST_RESET;
					rst_cnt_next = '0;
				end
			end
			wdt_pkg::ST_RESET: begin
				rst_cnt_next = rst_cnt_reg + 1'b1;
				if (rst_cnt_reg == wdt_pkg::RST_CNT_LAST) begin
					state_next = wdt_pkg::ST_RUN;
					rst_cnt_next = '0;
				end
			end
			default: begin
				state_next = wdt_pkg::ST_RUN;
			end
		endcase
		sys_reset_next = (state_next == wdt_pkg::ST_RESET);
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			state_reg <= wdt_pkg::ST_RUN;
			rst_cnt_reg <= '0;
			sys_reset_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			rst_cnt_reg <= rst_cnt_next;
			sys_reset_reg <= sys_reset_next;
		end
	end

	assign sys_reset = sys_reset_reg;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	// Counts how long the system reset has stood, so that its length is
	// checked on a small counter rather than by a long repetition.
	logic [4:0] hold_len_reg;
	logic [4:0] hold_len_next;

	always_comb begin
		hold_len_next = 5'h00;
		if (sys_reset_reg) begin
			hold_len_next = hold_len_reg + 5'h01;
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			hold_len_reg <= 5'h00;
		end else begin
			hold_len_reg <= hold_len_next;
		end
	end

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!nrst);

	// A terminal count in the cycle that fires the system reset is
	// swallowed by the reset, which clears every flag.
	sequence s_c1_terminal;
		c1_count == C1_MATCH && !in_reset && !fire;
	endsequence

	sequence s_third_miss;
		c0_hit && miss_reg == 2'h2 && !c0_clear && !c0_irq_ack && !in_reset;
	endsequence

	tick_raise_a: assert property (
		s_c1_terminal |=> c1_hit ##1 tick_irq)
		else $error("tick interrupt missing after counter 1 terminal");

	tick_wrap_a: assert property (
		s_c1_terminal |=> c1_count == 16'h0000)
		else $error("counter 1 did not wrap at terminal");

	c0_irq_set_a: assert property (c0_hit && !in_reset |=> c0_irq)
		else $error("counter 0 interrupt not raised");

	c0_terminal_a: assert property (
		c0_count == c0_match && lf_step_reg && !c0_clear && !in_reset
		|=> c0_hit && c0_count == 16'h0000)
		else $error("counter 0 did not hit at programmed terminal");

	third_miss_a: assert property (s_third_miss |=> sys_reset)
		else $error("no system reset after third unhandled interrupt");

	early_reset_a: assert property (
		$rose(sys_reset) |-> $past(miss_reg) == 2'h2 && $past(c0_hit))
		else $error("system reset without three unhandled interrupts");

	reset_hold_a: assert property (
		$fell(sys_reset)
		|-> hold_len_reg == 5'(wdt_pkg::RESET_PULSE_CYCLES))
		else $error("system reset pulse length wrong");

	reset_long_a: assert property (
		sys_reset |-> hold_len_reg < 5'(wdt_pkg::RESET_PULSE_CYCLES))
		else $error("system reset pulse stands too long");

	clear_window_a: assert property (
		c0_clear && !c0_hit |=> miss_reg == 2'h0 && c0_count == 16'h0000)
		else $error("counter 0 clear did not restart the window");

	c2_step_a: assert property (
		lf_step_reg && !in_reset
		|=> c2_count == $past(c2_count) + 32'h0000_0001 || c2_hit)
		else $error("counter 2 did not advance on a step");

	lf_single_a: assert property (lf_step_reg |=> !lf_step_reg [*3])
		else $error("low-frequency step not a single pulse");

endmodule

// File: verification/tb_top.sv
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------------------------------
	// Timing used by the expectations
	// ----------------------------------------------------------------
	localparam int TICK = 40;
	localparam int LF = wdt_pkg::LF_DIV_CYCLES;
	// A terminal value of 3 means four low-frequency steps per hit.
	localparam int C0_PER = 4 * LF;

	logic ref_clk;
	logic nrst;
	logic c0_clear;
	logic c0_irq_ack;
	logic tick_irq_ack;
	logic [wdt_pkg::C0_WIDTH-1:0] c0_match;
	logic tick_irq;
	logic c0_irq;
	logic sys_reset;
	logic [wdt_pkg::C0_WIDTH-1:0] c0_count;
	logic [wdt_pkg::C1_WIDTH-1:0] c1_count;
	logic [wdt_pkg::C2_WIDTH-1:0] c2_count;
	int miscompares = 0;
	int n_compared = 0;
	int cyc = 0;
	int rst_seen = 0;

	watchdog_timer #(.TICK_CYCLES(TICK)) DUT (
		.ref_clk(ref_clk), .nrst(nrst), .c0_clear(c0_clear),
		.c0_match(c0_match), .c0_irq_ack(c0_irq_ack),
		.tick_irq_ack(tick_irq_ack), .tick_irq(tick_irq), .c0_irq(c0_irq),
		.sys_reset(sys_reset), .c0_count(c0_count), .c1_count(c1_count),
		.c2_count(c2_count)
	);

	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end

	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (sys_reset === 1'b1) begin
			rst_seen <= rst_seen + 1;
		end
	end

	task automatic chk(input string what, input logic [31:0] exp,
			input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("Error %s expected %0h seen %0h", what, exp, got);
		end
	endtask

	function automatic logic sel_val(input int sel);
		return (sel == 0) ? tick_irq : (sel == 1) ? c0_irq : sys_reset;
	endfunction

	// Waits at falling edges, under a limit, for one of the outputs.
	task automatic wait_for(input int sel, input int lim, output int t);
		int n;
		n = 0;
		while (sel_val(sel) !== 1'b1 && n < lim) begin
			@(negedge ref_clk);
			n++;
		end
		t = cyc;
		chk("output rose in time", 1, n < lim);
	endtask

	task automatic pulse(ref logic s);
		s = 1'b1;
		@(negedge ref_clk);
		s = 1'b0;
	endtask

	task automatic test_tick;
		int a;
		int b;
		wait_for(0, 2 * TICK + 4, a);
		pulse(tick_irq_ack);
		chk("tick_irq after ack", 0, tick_irq);
		wait_for(0, 2 * TICK + 4, b);
		chk("tick period", TICK, b - a);
		pulse(tick_irq_ack);
		$display("tick test done");
	endtask

	task automatic test_c0_ack;
		int a;
		int b;
		int r0;
		r0 = rst_seen;
		pulse(c0_clear);
		wait_for(1, C0_PER + LF + 4, a);
		pulse(c0_irq_ack);
		for (int i = 0; i < 3; i++) begin
			chk("c0_irq after ack", 0, c0_irq);
			wait_for(1, C0_PER + 4, b);
			chk("counter 0 period", C0_PER, b - a);
			a = b;
			pulse(c0_irq_ack);
		end
		// The count has just wrapped, so a new terminal takes effect cleanly.
		c0_match = 16'h0001;
		wait_for(1, 2 * LF + 4, b);
		chk("counter 0 short period", 2 * LF, b - a);
		pulse(c0_irq_ack);
		c0_match = 16'h0003;
		chk("no reset while acked", 0, rst_seen - r0);
		$display("counter 0 interrupt test done");
	endtask

	task automatic test_clear;
		int r0;
		int c2a;
		int d;
		r0 = rst_seen;
		for (int i = 0; i < 6; i++) begin
			pulse(c0_clear);
			chk("c0_count after clear", 0, c0_count);
			c2a = int'(c2_count);
			repeat (2 * LF + 100) @(negedge ref_clk);
			chk("c0_irq with clears", 0, c0_irq);
			d = int'(c2_count) - c2a;
			chk("counter 2 advance", 1, d == 2 || d == 3);
		end
		chk("no reset with clears", 0, rst_seen - r0);
		$display("clear test done");
	endtask

	task automatic test_reset;
		int t0;
		int a;
		int d;
		t0 = cyc;
		pulse(c0_clear);
		wait_for(2, 13 * LF, a);
		d = a - t0;
		chk("reset delay in window", 1,
			(d >= 11 * LF) && (d <= 12 * LF + 3));
		for (int i = 0; i < 16; i++) begin
			chk("sys_reset pulse", 1, sys_reset);
			chk("c0_count in reset", 0, c0_count);
			if (i > 0) begin
				chk("c1_count in reset", 0, c1_count);
				chk("c0_irq in reset", 0, c0_irq);
				chk("c2_count in reset", 0, c2_count);
			end
			@(negedge ref_clk);
		end
		chk("sys_reset released", 0, sys_reset);
		wait_for(0, 2 * TICK + 4, a);
		$display("reset test done");
	endtask

	task automatic complete_run;
		$display("compared %0d miscompares %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	initial begin
		#(80000 * 40);
		miscompares++;
		$display("Error watchdog expired expected 0 seen 1");
		complete_run();
	end

	initial begin
		nrst = 1'b0;
		c0_clear = 1'b0;
		c0_irq_ack = 1'b0;
		tick_irq_ack = 1'b0;
		c0_match = 16'h0003;
		repeat (2) @(negedge ref_clk);
		nrst = 1'b1;
		chk("c0 width", 16, $bits(c0_count));
		chk("c1 width", 16, $bits(c1_count));
		chk("c2 width", 32, $bits(c2_count));
		test_tick();
		test_c0_ack();
		test_clear();
		test_reset();
		complete_run();
	end
endmodule
